// [verilog/sto_sequencer.sv]
// Purpose: dual channel safe torque off sequencer of a servo drive
// Assumes: all inputs synchronous to CORE_CLK_I at 25 MHz
// Notes: channel inputs are high while current flows (normal operation)
// Operation
// R1: either channel off enters safe stop
// R2: both on, servo-on off, goes idle block
// R3: servo-on held keeps safe stop until released
// R4: main power off also waits servo-on release
// R5: forced servo-on source never leaves safe stop
// R6: channels disagree 10 s raises mismatch alarm
// R7: both off removes motor power within 20 ms
// R8: off pulses 0.5 ms or shorter ignored
// R9: channel on means run, off means request
// R10: safety circuit drives both channels redundantly
// R11: safe stop acts during utility functions
// R12: interrupted utility needs cancel and restart
// R13: safe stop rejects servo-on, ready off
// R14: ready returns in idle block, channels on
// R15: brake engages at once, delay bypassed
// R16: dynamic brake stops motor when selected
// R17: error cleared or kept per clear select
// R18: error over limit raises overflow alarm
// R19: retained error moved at next servo-on
// R20: host halts references, clears error itself
// R21: no alarm or code outputs in safe stop; mismatch and overflow alarm outputs stay driven
// R22: ready needs power, no stop, no alarm
// R23: mismatch alarm latched until reset, agreed
`timescale 1ns/10ps
`include "sto_regs.svh"
module sto_sequencer
  import sto_pkg::*;
#(
  parameter int FILT_CYC = `STO_FILT_CYC,
  parameter int MISM_CYC = `STO_MISM_CYC,
  parameter int OFF_MAX_CYC = `STO_OFF_MAX_CYC,
  parameter int DLY_W = 16
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic SAFE_STOP_REQUEST_A_N_I,
  input wire logic SAFE_STOP_REQUEST_B_N_I,
  input wire logic SERVO_ON_REQ_I,
  input wire logic SERVO_ON_SOURCE_SELECT_I,
  input wire logic MAIN_POWER_ON_I,
  input wire logic ABS_ENCODER_USED_I,
  input wire logic ABSOLUTE_DATA_REQUEST_I,
  input wire logic SERVO_ALARM_IN_I,
  input wire logic ALARM_RESET_I,
  input wire logic UTILITY_ACTIVE_I,
  input wire logic STOP_METHOD_SETTING_I,
  input wire logic [DLY_W-1:0] BRAKE_RELEASE_DELAY_SETTING_I,
  input wire logic [1:0] ERROR_CLEAR_SELECT_I,
  input wire logic POSITION_ERROR_CLEAR_IN_I,
  input wire logic REF_PULSE_I,
  input wire logic REF_DIR_I,
  output logic MOTOR_POWER_EN_O,
  output logic HARDWIRED_SAFE_STOP_STATE_O,
  output logic IDLE_BLOCK_STATE_O,
  output logic SERVO_READY_O,
  output logic HOLDING_BRAKE_OUT_O,
  output logic DYN_BRAKE_O,
  output logic UTILITY_PERMIT_O,
  output logic DUAL_INPUT_MISMATCH_ALARM_O,
  output logic POSITION_ERROR_OVERFLOW_ALARM_O,
  output logic SERVO_ALARM_OUT_O,
  output logic [2:0] ALARM_CODE_OUT_O,
  output logic MOTION_STEP_O,
  output logic MOTION_DIR_O
);
  localparam int MW = $clog2(MISM_CYC + 1);
  localparam logic [MW-1:0] MISM_LAST = MW'(MISM_CYC - 1);

  sto_state_t state_q, state_d;
  logic a_on, b_on, both_on, son_eff;
  logic [MW-1:0] mism_cnt_q;
  logic mism_q, ovf, any_alarm;
  logic [DLY_W-1:0] hold_q;
  logic power_q, ready_q, brake_q, dyn_q, util_blk_q, alm_q;
  logic [2:0] code_q;
  logic step, dir;

  if (MISM_CYC < 2 || OFF_MAX_CYC <= FILT_CYC + 4) begin : g_chk
    $error("timing parameters cannot be served");
  end

  // per channel pulse filters
  sto_input_filter #(.FILT_CYC(FILT_CYC)) u_filt_a (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .raw_on_i(SAFE_STOP_REQUEST_A_N_I), // R9
    .on_o(a_on)
  );
  sto_input_filter #(.FILT_CYC(FILT_CYC)) u_filt_b (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .raw_on_i(SAFE_STOP_REQUEST_B_N_I), // R9
    .on_o(b_on)
  );

  // forced source makes servo-on permanently requested
  assign both_on = a_on && b_on;
  assign son_eff = SERVO_ON_SOURCE_SELECT_I || SERVO_ON_REQ_I; // R5
  assign any_alarm = mism_q || ovf || SERVO_ALARM_IN_I;

  // next state; safe stop overrides utility activity too
  always_comb begin
    state_d = state_q;
    case (state_q)
      STO_SAFE_STOP: begin
        if (both_on && !son_eff) begin
          state_d = STO_IDLE_BLOCK; // R2 R3 R4
        end
      end
      STO_IDLE_BLOCK: begin
        if (son_eff && ready_q) begin
          state_d = STO_RUN; // R13
        end
      end
      STO_RUN: begin
        if (!son_eff || any_alarm) begin
          state_d = STO_IDLE_BLOCK;
        end
      end
      default: state_d = STO_SAFE_STOP;
    endcase
    if (!both_on) begin
      state_d = STO_SAFE_STOP; // R1 R11
    end
  end

  // state register, starts in safe stop
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= STO_SAFE_STOP;
    end else begin
      state_q <= state_d;
    end
  end

  // mismatch timer runs while the channels disagree
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mism_cnt_q <= '0;
    end else if (a_on == b_on) begin
      mism_cnt_q <= '0;
    end else if (mism_cnt_q != MISM_LAST) begin
      mism_cnt_q <= mism_cnt_q + 1'b1; // R6
    end
  end

  // mismatch alarm latch, set wins over reset
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mism_q <= 1'b0;
    end else if (a_on != b_on && mism_cnt_q == MISM_LAST) begin
      mism_q <= 1'b1; // R6
    end else if (ALARM_RESET_I && a_on == b_on) begin
      mism_q <= 1'b0; // R23
    end
  end

  // servo-off delay holds power after the brake engages, not in safe stop
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hold_q <= '0;
    end else if (state_q == STO_SAFE_STOP) begin
      hold_q <= '0; // R15
    end else if (state_q == STO_RUN) begin
      hold_q <= BRAKE_RELEASE_DELAY_SETTING_I;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  // power stage, brake and dynamic brake drives
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      power_q <= 1'b0;
      brake_q <= 1'b0;
      dyn_q <= 1'b0;
    end else begin
      power_q <= state_q == STO_RUN || (state_q == STO_IDLE_BLOCK && hold_q != '0); // R7
      brake_q <= state_q == STO_RUN; // R15
      dyn_q <= state_q == STO_SAFE_STOP && STOP_METHOD_SETTING_I; // R16
    end
  end

  // servo ready qualification
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= MAIN_POWER_ON_I && state_q != STO_SAFE_STOP && !any_alarm &&
                 (!ABS_ENCODER_USED_I || ABSOLUTE_DATA_REQUEST_I); // R13 R14 R22
    end
  end

  // utility interrupted by safe stop stays blocked until cancelled
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      util_blk_q <= 1'b0;
    end else if (state_q == STO_SAFE_STOP && UTILITY_ACTIVE_I) begin
      util_blk_q <= 1'b1; // R12
    end else if (!UTILITY_ACTIVE_I) begin
      util_blk_q <= 1'b0;
    end
  end

  // servo alarm and code outputs are silent in safe stop; mismatch and overflow alarm outputs stay driven
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      alm_q <= 1'b0;
      code_q <= `STO_CODE_NONE;
    end else if (state_q == STO_SAFE_STOP) begin
      alm_q <= 1'b0; // R21
      code_q <= `STO_CODE_NONE;
    end else begin
      alm_q <= any_alarm;
      code_q <= mism_q ? `STO_CODE_MISM : ovf ? `STO_CODE_OVF :
                SERVO_ALARM_IN_I ? `STO_CODE_OTHER : `STO_CODE_NONE;
    end
  end

  // position error handling
  sto_err_counter u_err (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .safe_stop_i(state_q == STO_SAFE_STOP),
    .idle_i(state_q == STO_IDLE_BLOCK),
    .running_i(state_q == STO_RUN),
    .clear_sel_i(ERROR_CLEAR_SELECT_I),
    .clr_in_i(POSITION_ERROR_CLEAR_IN_I),
    .ref_pulse_i(REF_PULSE_I),
    .ref_dir_i(REF_DIR_I),
    .alarm_reset_i(ALARM_RESET_I),
    .ovf_o(ovf),
    .step_o(step),
    .dir_o(dir)
  );

  // output assignments
  assign MOTOR_POWER_EN_O = power_q;
  assign HARDWIRED_SAFE_STOP_STATE_O = state_q == STO_SAFE_STOP;
  assign IDLE_BLOCK_STATE_O = state_q == STO_IDLE_BLOCK;
  assign SERVO_READY_O = ready_q;
  assign HOLDING_BRAKE_OUT_O = brake_q;
  assign DYN_BRAKE_O = dyn_q;
  assign UTILITY_PERMIT_O = !util_blk_q && state_q != STO_SAFE_STOP;
  assign DUAL_INPUT_MISMATCH_ALARM_O = mism_q;
  assign POSITION_ERROR_OVERFLOW_ALARM_O = ovf;
  assign SERVO_ALARM_OUT_O = alm_q;
  assign ALARM_CODE_OUT_O = code_q;
  assign MOTION_STEP_O = step;
  assign MOTION_DIR_O = dir;

  // helper: cycles with both raw channels off and power still on
  logic [31:0] off_cnt_q;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      off_cnt_q <= '0;
    end else if (!SAFE_STOP_REQUEST_A_N_I && !SAFE_STOP_REQUEST_B_N_I && power_q) begin
      off_cnt_q <= off_cnt_q + 1'b1;
    end else begin
      off_cnt_q <= '0;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_in_stop;
    state_q == STO_SAFE_STOP;
  endsequence
  sequence s_release;
    s_in_stop ##0 (both_on && !son_eff);
  endsequence

  a_stop_on_channel: assert property (!both_on |=> s_in_stop) // R1
    else $error("channel off did not enter safe stop");
  a_release_to_idle: assert property (s_release |=> state_q == STO_IDLE_BLOCK) // R2
    else $error("safe stop not released to idle block");
  a_son_holds_stop: assert property ((s_in_stop ##0 SERVO_ON_REQ_I) |=> s_in_stop) // R3
    else $error("safe stop left with servo-on held");
  a_forced_son_stop: assert property ((s_in_stop ##0 SERVO_ON_SOURCE_SELECT_I) |=> s_in_stop) // R5
    else $error("forced servo-on left safe stop");
  a_mismatch_alarm: assert property ((a_on != b_on && mism_cnt_q == MISM_LAST) |=> mism_q) // R6
    else $error("mismatch alarm not raised");
  a_mismatch_held: assert property ((mism_q && !ALARM_RESET_I) |=> mism_q) // R23
    else $error("mismatch alarm dropped without reset");
  a_power_off_time: assert property (off_cnt_q < 32'(OFF_MAX_CYC)) // R7
    else $error("motor power not removed in time");
  a_ready_in_stop: assert property (s_in_stop |=> !ready_q) // R13
    else $error("ready shown in safe stop");
  a_ready_return: assert property ((state_q == STO_IDLE_BLOCK && MAIN_POWER_ON_I && !any_alarm
    && !ABS_ENCODER_USED_I) |=> ready_q) // R14
    else $error("ready not returned in idle block");
  a_brake_at_stop: assert property (s_in_stop |=> !brake_q && !power_q) // R15
    else $error("brake or power held in safe stop");
  a_dyn_brake: assert property ((s_in_stop ##0 STOP_METHOD_SETTING_I) |=> dyn_q) // R16
    else $error("dynamic brake not applied");
  a_alarm_quiet: assert property (s_in_stop |=> !alm_q && code_q == `STO_CODE_NONE) // R21
    else $error("alarm outputs driven in safe stop");
  a_utility_block: assert property ((s_in_stop ##0 UTILITY_ACTIVE_I) |=> !UTILITY_PERMIT_O) // R12
    else $error("interrupted utility resumed");
endmodule

// [verilog/sto_regs.svh]
// Purpose: constants for the safe torque off sequencer
// Assumes: core clock of 25 MHz
// Notes: times keep their printed unit; cycle counts derive from them
`ifndef STO_REGS_SVH
`define STO_REGS_SVH

`define STO_CLK_KHZ 25000
// shortest off time that still counts as a request (exclusive)
`define STO_FILT_TIME_US 500
// channel disagreement allowed before the mismatch alarm
`define STO_MISM_TIME_MS 10000
// longest time from both channels off to motor power removed
`define STO_OFF_MAX_TIME_US 20000
// least time rounds up, longest rounds down
`define STO_FILT_CYC ((`STO_FILT_TIME_US * `STO_CLK_KHZ + 999) / 1000)
`define STO_MISM_CYC (`STO_MISM_TIME_MS * `STO_CLK_KHZ)
`define STO_OFF_MAX_CYC (`STO_OFF_MAX_TIME_US * `STO_CLK_KHZ / 1000)

// error clear selection value that keeps the position error
`define STO_CLR_SEL_KEEP 2'h1
// default position error limit
`define STO_ERR_LIMIT 24'h0FFFFF
// alarm codes on the three code outputs
`define STO_CODE_NONE 3'h0
`define STO_CODE_OVF 3'h2
`define STO_CODE_MISM 3'h5
`define STO_CODE_OTHER 3'h7

`endif

// [verilog/sto_pkg.sv]
// Purpose: shared types of the safe torque off sequencer
// Assumes: nothing
// Notes: state codes are gray along idle, run, safe stop
package sto_pkg;
  typedef enum logic [1:0] {
    STO_IDLE_BLOCK = 2'h0,
    STO_RUN = 2'h1,
    STO_SAFE_STOP = 2'h3
  } sto_state_t;
endpackage

// [verilog/sto_input_filter.sv]
// Purpose: pulse filter for one shut-off request channel
// Assumes: input synchronous to the clock
// Notes: return to on is immediate, off needs more than FILT_CYC samples
`timescale 1ns/10ps
`include "sto_regs.svh"
module sto_input_filter #(
  parameter int FILT_CYC = `STO_FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic raw_on_i,
  output logic on_o
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_CYC);

  logic [CW-1:0] cnt_q;
  logic on_q;

  if (FILT_CYC < 1) begin : g_chk
    $error("FILT_CYC must be at least one");
  end

  // off time counter, restarts whenever the channel is on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (raw_on_i) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // short dips are not a request; starts off so reset is safe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_q <= 1'b0;
    end else if (raw_on_i) begin
      on_q <= 1'b1;
    end else if (cnt_q == LAST) begin
      on_q <= 1'b0; // R8
    end
  end

  assign on_o = on_q;

  a_short_dip_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (on_q && !raw_on_i && cnt_q != LAST) |=> on_q) // R8
    else $error("short off dip was taken as request");
endmodule

// [verilog/sto_err_counter.sv]
// Purpose: position error accumulator with clear policy and overflow
// Assumes: one reference pulse per cycle at most
// Notes: while running the retained error is paid out as motion steps
`timescale 1ns/10ps
`include "sto_regs.svh"
module sto_err_counter #(
  parameter int ERR_W = 25,
  parameter logic [23:0] ERR_LIMIT = `STO_ERR_LIMIT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic safe_stop_i,
  input wire logic idle_i,
  input wire logic running_i,
  input wire logic [1:0] clear_sel_i,
  input wire logic clr_in_i,
  input wire logic ref_pulse_i,
  input wire logic ref_dir_i,
  input wire logic alarm_reset_i,
  output logic ovf_o,
  output logic step_o,
  output logic dir_o
);
  logic signed [ERR_W-1:0] err_q;
  logic signed [ERR_W-1:0] delta;
  logic over;
  logic ovf_q;
  logic step_q;
  logic dir_q;

  if (ERR_W < 25) begin : g_chk
    $error("ERR_W must exceed the limit width");
  end

  function automatic logic [ERR_W-1:0] mag(input logic signed [ERR_W-1:0] v);
    mag = v[ERR_W-1] ? ERR_W'(-v) : ERR_W'(v);
  endfunction

  assign delta = ref_pulse_i ? (ref_dir_i ? ERR_W'(1) : -ERR_W'(1)) : '0;
  assign over = mag(err_q) > ERR_W'(ERR_LIMIT);

  // error register: clear policy, accumulation, pay-out when running
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q <= '0;
    end else if (safe_stop_i && clear_sel_i != `STO_CLR_SEL_KEEP) begin
      err_q <= '0; // R17
    end else if ((safe_stop_i || idle_i) && clr_in_i) begin
      err_q <= '0;
    end else if (running_i && err_q != '0) begin
      err_q <= err_q + delta - (err_q[ERR_W-1] ? -ERR_W'(1) : ERR_W'(1)); // R19
    end else begin
      err_q <= err_q + delta; // R17
    end
  end

  // motion step output while retained error is moved
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      step_q <= running_i && err_q != '0; // R19
      dir_q <= !err_q[ERR_W-1];
    end
  end

  // overflow alarm, set wins over reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_q <= 1'b0;
    end else if (over) begin
      ovf_q <= 1'b1; // R18
    end else if (alarm_reset_i) begin
      ovf_q <= 1'b0;
    end
  end

  assign ovf_o = ovf_q;
  assign step_o = step_q;
  assign dir_o = dir_q;

  a_err_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    over |=> ovf_q) // R18
    else $error("position error overflow not flagged");
endmodule

// [sim/sto_safety_unit.sv]
// Purpose: safety unit model that drives the two shut-off request channels
// Assumes: commands change just after a falling clock edge
// Notes: b_stuck_i breaks redundancy on purpose for the disagreement test
`timescale 1ns/10ps
module sto_safety_unit (
  input wire logic guard_open_i,
  input wire logic b_stuck_i,
  output logic chan_a_n_o,
  output logic chan_b_n_o
);
  // both channels open together when the guard opens, unless b_stuck_i holds channel b on; high means current flows
  assign chan_a_n_o = ~guard_open_i;
  assign chan_b_n_o = ~(guard_open_i & ~b_stuck_i);
endmodule

// [sim/tb_sto_sequencer.sv]
// Purpose: self-checking bench of the safe torque off sequencer
// Assumes: shortened counts FILT 4, MISM 20, OFFM 32
// Notes: inputs change on the falling edge; random values from an lfsr
`timescale 1ns/10ps
`include "sto_regs.svh"
module tb_sto_sequencer;
  import sto_pkg::*;
  localparam int FILT = 4;
  localparam int MISM = 20;
  localparam int OFFM = 32;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic guard_open = 1'b0, b_stuck = 1'b0, chan_a_n, chan_b_n;
  logic son = 1'b0, src_sel = 1'b0, pwr = 1'b1, abs_used = 1'b0, abs_req = 1'b0;
  logic alm_in = 1'b0, alm_rst = 1'b0, util = 1'b0, dyn_sel = 1'b1;
  logic [15:0] bk_dly = 16'h0003;
  logic [1:0] clr_sel = 2'h0;
  // host keeps references halted unless a scenario sends them
  logic clr_in = 1'b0, ref_p = 1'b0, ref_d = 1'b1;
  logic pwr_en, hss, idle, rdy, bk, dyn, permit, mism, ovf, alm_o, step, dir;
  logic [2:0] code;
  logic [31:0] rnd = 32'h7726;
  int bad_count = 0;
  int total_checks = 0;
  int n, m, cnt;

  // free-running core clock
  always #20 clk = ~clk;

  sto_safety_unit u_sto_safety_unit (.guard_open_i(guard_open), .b_stuck_i(b_stuck),
    .chan_a_n_o(chan_a_n), .chan_b_n_o(chan_b_n));

  sto_sequencer #(.FILT_CYC(FILT), .MISM_CYC(MISM), .OFF_MAX_CYC(OFFM)) u_sto_sequencer (
    .CORE_CLK_I(clk), .RESETN_I(rst_n),
    .SAFE_STOP_REQUEST_A_N_I(chan_a_n), .SAFE_STOP_REQUEST_B_N_I(chan_b_n),
    .SERVO_ON_REQ_I(son), .SERVO_ON_SOURCE_SELECT_I(src_sel), .MAIN_POWER_ON_I(pwr),
    .ABS_ENCODER_USED_I(abs_used), .ABSOLUTE_DATA_REQUEST_I(abs_req),
    .SERVO_ALARM_IN_I(alm_in), .ALARM_RESET_I(alm_rst), .UTILITY_ACTIVE_I(util),
    .STOP_METHOD_SETTING_I(dyn_sel), .BRAKE_RELEASE_DELAY_SETTING_I(bk_dly),
    .ERROR_CLEAR_SELECT_I(clr_sel), .POSITION_ERROR_CLEAR_IN_I(clr_in),
    .REF_PULSE_I(ref_p), .REF_DIR_I(ref_d), .MOTOR_POWER_EN_O(pwr_en),
    .HARDWIRED_SAFE_STOP_STATE_O(hss), .IDLE_BLOCK_STATE_O(idle), .SERVO_READY_O(rdy),
    .HOLDING_BRAKE_OUT_O(bk), .DYN_BRAKE_O(dyn), .UTILITY_PERMIT_O(permit),
    .DUAL_INPUT_MISMATCH_ALARM_O(mism), .POSITION_ERROR_OVERFLOW_ALARM_O(ovf),
    .SERVO_ALARM_OUT_O(alm_o), .ALARM_CODE_OUT_O(code), .MOTION_STEP_O(step),
    .MOTION_DIR_O(dir));

  // next lfsr value
  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected ready level from power, encoder and alarm inputs
  function automatic logic exp_ready(input logic p, input logic au, input logic ar,
                                     input logic al);
    return p & ~al & (~au | ar);
  endfunction

  // retained steps expected after a safe stop with refs
  function automatic int exp_steps(input logic [1:0] sel, input logic clr, input int refs);
    return (sel == `STO_CLR_SEL_KEEP && !clr) ? refs : 0;
  endfunction

  function automatic logic pick(input int w);
    case (w)
      0: return hss;
      1: return idle;
      2: return pwr_en;
      3: return mism;
      default: return bk;
    endcase
  endfunction

  task automatic chk(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  // wait for an output level, bounded
  task automatic wait_on(input int w, input logic v, input int lim, output int cyc);
    cyc = 0;
    while (pick(w) !== v && cyc < lim) begin
      tick(1);
      cyc++;
    end
  endtask

  task automatic go_run();
    son = 1'b1;
    wait_on(2, 1'b1, 10, n);
    chk(pwr_en, 1'b1, "power on run");
    chk(bk, 1'b1, "brake released run");
  endtask

  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #(40 * 5000);
    bad_count++;
    summarize();
  end

  // main sequence
  initial begin
    tick(5);
    chk(hss, 1'b1, "safe stop in reset");
    chk(pwr_en, 1'b0, "power off in reset");
    rst_n = 1'b1;
    wait_on(1, 1'b1, 10, n);
    chk(idle, 1'b1, "idle after release");
    tick(2);
    chk(rdy, exp_ready(pwr, abs_used, abs_req, alm_in), "ready idle");
    pwr = 1'b0;
    tick(3);
    chk(rdy, exp_ready(pwr, abs_used, abs_req, alm_in), "ready no power");
    pwr = 1'b1;
    abs_used = 1'b1;
    tick(3);
    chk(rdy, exp_ready(pwr, abs_used, abs_req, alm_in), "ready no abs req");
    abs_req = 1'b1;
    tick(3);
    chk(rdy, exp_ready(pwr, abs_used, abs_req, alm_in), "ready abs req");
    go_run();
    // short random off pulses are ignored
    for (int k = 0; k < 6; k++) begin
      rnd = next_rnd(rnd);
      guard_open = 1'b1;
      tick(int'(rnd[1:0]) + 1);
      guard_open = 1'b0;
      tick(FILT + 3);
      chk(hss, 1'b0, "glitch ignored");
      chk(pwr_en, 1'b1, "glitch keeps power");
    end
    // both channels off while running
    dyn_sel = rnd[4];
    guard_open = 1'b1;
    wait_on(2, 1'b0, OFFM, n);
    chk(n < OFFM, 1'b1, "power removal time");
    chk(hss, 1'b1, "safe stop entered");
    chk(bk, 1'b0, "brake with power");
    chk(dyn, dyn_sel, "dynamic brake");
    chk(rdy, 1'b0, "ready off safe stop");
    // servo-on still held when channels return
    guard_open = 1'b0;
    tick(10);
    chk(hss, 1'b1, "servo-on holds stop");
    son = 1'b0;
    wait_on(1, 1'b1, 10, n);
    chk(idle, 1'b1, "idle after servo-off");
    tick(2);
    chk(rdy, 1'b1, "ready back");
    // normal servo-off keeps power through the brake delay
    go_run();
    son = 1'b0;
    wait_on(4, 1'b0, 10, n);
    chk(pwr_en, 1'b1, "power held after brake");
    tick(8);
    // forced servo-on never leaves stop
    src_sel = 1'b1;
    guard_open = 1'b1;
    tick(FILT + 4);
    guard_open = 1'b0;
    tick(20);
    chk(hss, 1'b1, "forced servo-on stays");
    src_sel = 1'b0;
    wait_on(1, 1'b1, 10, n);
    // main power off with servo-on held
    pwr = 1'b0;
    son = 1'b1;
    guard_open = 1'b1;
    tick(FILT + 4);
    guard_open = 1'b0;
    tick(10);
    chk(hss, 1'b1, "power off keeps stop");
    son = 1'b0;
    wait_on(1, 1'b1, 10, n);
    chk(idle, 1'b1, "idle after power case");
    pwr = 1'b1;
    // one channel stuck on raises mismatch
    b_stuck = 1'b1;
    guard_open = 1'b1;
    wait_on(3, 1'b1, MISM + FILT + 10, n);
    chk(n >= MISM && n <= MISM + FILT + 4, 1'b1, "mismatch time");
    chk(mism, 1'b1, "mismatch alarm");
    chk(hss, 1'b1, "single channel stop");
    chk(alm_o, 1'b0, "alarm out in stop");
    chk(code === 3'h0, 1'b1, "alarm code in stop");
    alm_rst = 1'b1;
    tick(1);
    alm_rst = 1'b0;
    tick(2);
    chk(mism, 1'b1, "alarm latched");
    guard_open = 1'b0;
    b_stuck = 1'b0;
    tick(3);
    alm_rst = 1'b1;
    tick(1);
    alm_rst = 1'b0;
    tick(2);
    chk(mism, 1'b0, "alarm reset");
    wait_on(1, 1'b1, 10, n);
    // other alarm outside safe stop drives alarm outputs and drops ready
    alm_in = 1'b1;
    tick(2);
    chk(alm_o, 1'b1, "alarm out outside stop");
    chk(code === `STO_CODE_OTHER, 1'b1, "alarm code outside stop");
    chk(rdy, exp_ready(pwr, abs_used, abs_req, alm_in), "ready with alarm");
    alm_in = 1'b0;
    tick(2);
    chk(rdy, exp_ready(pwr, abs_used, abs_req, alm_in), "ready alarm gone");
    // utility interrupted by safe stop
    util = 1'b1;
    guard_open = 1'b1;
    tick(FILT + 4);
    chk(hss, 1'b1, "stop during utility");
    chk(permit, 1'b0, "utility blocked");
    guard_open = 1'b0;
    tick(6);
    chk(permit, 1'b0, "utility stays blocked");
    util = 1'b0;
    tick(2);
    util = 1'b1;
    tick(2);
    chk(permit, 1'b1, "utility restarted");
    util = 1'b0;
    // retained error paid out per clear select
    for (int s = 0; s < 3; s++) begin
      clr_sel = (s == 1) ? 2'h0 : 2'h1;
      rnd = next_rnd(rnd);
      m = int'(rnd[2:0]) + 1;
      guard_open = 1'b1;
      wait_on(0, 1'b1, FILT + 6, n);
      ref_p = 1'b1;
      tick(m);
      ref_p = 1'b0;
      guard_open = 1'b0;
      wait_on(1, 1'b1, 10, n);
      // last pass: host clears the kept error in idle block
      clr_in = (s == 2);
      tick(2);
      clr_in = 1'b0;
      son = 1'b1;
      cnt = 0;
      repeat (30) begin
        tick(1);
        if (step === 1'b1) begin
          cnt++;
          chk(dir, 1'b1, "step direction");
        end
      end
      chk(cnt == exp_steps(clr_sel, s == 2, m), 1'b1, "retained steps");
      chk(ovf, 1'b0, "no overflow below limit");
      son = 1'b0;
      tick(6);
    end
    summarize();
  end
endmodule
